/* silm_pkg.sv */
// constants shared by the interrupt line mapper and its target timer
// assumes a single 100 MHz system clock and an active-high reset
package silm_pkg;

    // clock and base time reference
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BASE_TICK_NS = 625000; // 625 us base reference
    localparam int unsigned BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
    localparam int BASE_CNT_W = 17;

    // gross timer resolution in base ticks
    localparam logic [3:0] GROSS_PRESCALE_LAST = 4'hF; // 16 base ticks

    // interrupt line numbers
    localparam int LINE_COUNT = 7;
    localparam int LINE_WAKEUP = 0;
    localparam int LINE_RADIO = 1;
    localparam int LINE_RSVD_A = 2;
    localparam int LINE_RSVD_B = 3;
    localparam int LINE_RFCAL = 4;
    localparam int LINE_ARBITER = 5;
    localparam int LINE_CRYPTO = 6;

    // sub-source bit positions of the combined radio line
    localparam int SRC_COUNT = 9;
    localparam int SRC_FINE = 0;
    localparam int SRC_GROSS = 1;
    localparam int SRC_TICK = 2;
    localparam int SRC_SLEEP_END = 3;
    localparam int SRC_FAULT = 4;
    localparam int SRC_RX = 5;
    localparam int SRC_EVENT = 6;
    localparam int SRC_LINK_CRYPT = 7;
    localparam int SRC_SW = 8;

    // target timer width and reset values
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;
    localparam logic [SRC_COUNT-1:0] SRC_RST = 9'h000;
    localparam logic [LINE_COUNT-1:0] LINE_RST = 7'h00;
    localparam logic [2:0] PRES_LINE_RST = 3'h0;

    // target timer states
    typedef enum logic [1:0] {
        SILM_TMR_IDLE = 2'b01,
        SILM_TMR_RUN = 2'b10
    } silm_tmr_state_t;

endpackage

/* silm_target_timer.sv */
// down counter of base or gross time units that pulses once when it expires
// assumes tick is a one-cycle pulse synchronous to sys_clk
module silm_target_timer
    import silm_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic tick, // one unit of time elapsed
    input wire logic load, // arm the timer with loadValue
    input wire logic [TIMER_W-1:0] loadValue, // units until expiry
    output logic expired // one-cycle expiry pulse
);

    typedef struct packed {
        silm_tmr_state_t state;
        logic [TIMER_W-1:0] count;
        logic expired;
    } silm_tmr_regs_t;

    silm_tmr_regs_t st_r;
    silm_tmr_regs_t st_nxt;

    // a load always wins, so software can re-arm a running timer
    always_comb begin
        st_nxt = st_r;
        st_nxt.expired = 1'b0;
        case (st_r.state)
            SILM_TMR_IDLE: begin
                if (load) begin
                    st_nxt.count = loadValue;
                    st_nxt.state = SILM_TMR_RUN;
                end
            end
            SILM_TMR_RUN: begin
                if (load) begin
                    st_nxt.count = loadValue;
                end else if (tick) begin
                    // zero or one left: expire on this unit
                    if (st_r.count <= 16'h0001) begin
                        st_nxt.expired = 1'b1;
                        st_nxt.count = TIMER_RST;
                        st_nxt.state = SILM_TMR_IDLE;
                    end else begin
                        st_nxt.count = st_r.count - 16'h0001;
                    end
                end
            end
            default: begin
                st_nxt.state = SILM_TMR_IDLE;
                st_nxt.count = TIMER_RST;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '{state: SILM_TMR_IDLE, count: TIMER_RST, expired: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired = st_r.expired;

endmodule // silm_target_timer

/* silm_line_map.sv */
// maps on-chip event sources onto processor interrupt lines 0 to 6
// assumes all inputs are synchronous to sys_clk; event inputs are pulses
// timing at the ports
// - every line output comes from a flip-flop
// - level lines 0, 4, 5 and 6 follow their inputs one edge later
// - line 1 shows a radio source on the edge that sets it
// - firstLine and firstLineValid lag irqLine by one more edge
// - radioSrcPending bits stay set until their clear bit is seen
// - a set and a clear in one cycle leave the bit set
//
// base time reference
// - a free-running counter makes a one-cycle tick
// - the tick period is BASE_TICK_LEN system clock cycles
// - the counter does not stop in sleep, so timers stay aligned
// - only the tick source itself is held off while asleep
// - a four-bit prescaler makes the gross unit from sixteen ticks
// - the prescaler runs from reset and is not touched by a load
// - so the first gross unit after a load may be short
//
// target timers
// - fine and gross timers share one small counter module
// - a load re-arms a timer at once, even while it runs
// - a target of zero or one expires on the next unit
// - the expiry pulse is registered inside the timer
// - the pending bit follows one edge after that pulse
//
// end of sleep
// - the sleeping level is kept from the previous edge
// - a high-to-low step sets the end-of-sleep source
// - the kept level resets low, so a pin that idles high
//   right after reset gives no false end of sleep
//
// sticky radio sources
// - all pulse inputs are single-cycle and synchronous
// - link AES and CCM completions share one source bit
// - software clears each bit by its own clear line
// - a clear held high blocks nothing that sets in that cycle
//
// reserved lines
// - lines 2 and 3 are tied low in the registered copy
// - they never glitch, as they come from flip-flops too
//
// presented line hint
// - the lowest set line number is worked out each cycle
// - it is taken from the registered lines, not the inputs
// - this costs one cycle but keeps the priority logic
//   off the input paths
// - with no line set the hint reads line 0 and valid low
//
// limitations
// - pulses shorter than one clock cycle are not seen
// - line 7 and above are not produced here
// - the processor's own priority levels are not modelled
//
// reset
// - asynchronous, active high, all state to its reset value
// - inputs may be driven from the first edge after release
module silm_line_map
    import silm_pkg::*;
#(
    parameter int unsigned BASE_TICK_LEN = BASE_TICK_CYCLES // cycles/tick
) (
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic radioSleepWakeupReq, // radio asks to wake system
    input wire logic radioSleeping, // level, radio core in sleep
    input wire logic fineLoad, // arm fine target timer
    input wire logic [TIMER_W-1:0] fineTarget, // fine units to expiry
    input wire logic grossLoad, // arm gross target timer
    input wire logic [TIMER_W-1:0] grossTarget, // gross units to expiry
    input wire logic radioFault, // pulse, bad behaviour seen
    input wire logic radioRxDone, // pulse, packet received
    input wire logic radioEventEnd, // pulse, radio event over
    input wire logic linkAesDone, // pulse, link AES finished
    input wire logic linkCcmDone, // pulse, link CCM finished
    input wire logic software_request_event, // pulse, software request
    input wire logic [SRC_COUNT-1:0] radioSrcClear, // per-source clears
    input wire logic rfCalIrq, // level, RF calibration
    input wire logic arbiterIrq, // level, bus arbiter
    input wire logic aesHashIrq, // level, AES or hash done
    input wire logic eccIrq, // level, curve engine
    output logic [LINE_COUNT-1:0] irqLine, // lines 0..6 to processor
    output logic [SRC_COUNT-1:0] radioSrcPending, // radio sources held
    output logic firstLineValid, // some line active
    output logic [2:0] firstLine // lowest active line number
);

    typedef struct packed {
        logic [BASE_CNT_W-1:0] baseCnt;
        logic baseTick;
        logic [3:0] grossPre;
        logic sleepPrev;
        logic [SRC_COUNT-1:0] pend;
        logic [LINE_COUNT-1:0] lines;
        logic presValid;
        logic [2:0] presLine;
    } silm_map_regs_t;

    silm_map_regs_t st_r;
    silm_map_regs_t st_nxt;
    logic grossTick;
    logic fineExpired;
    logic grossExpired;
    logic [SRC_COUNT-1:0] srcSet;

    // lowest set line number; gives the index only, valid is a separate OR
    function automatic logic [2:0] silm_lowest(
        input logic [LINE_COUNT-1:0] v
    );
        logic [2:0] idx;
        idx = PRES_LINE_RST;
        for (int i = LINE_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // gross unit ends on the 16th base tick
    assign grossTick = st_r.baseTick && (st_r.grossPre == GROSS_PRESCALE_LAST);

    silm_target_timer u_fine (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tick(st_r.baseTick),
        .load(fineLoad),
        .loadValue(fineTarget),
        .expired(fineExpired)
    );

    silm_target_timer u_gross (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tick(grossTick),
        .load(grossLoad),
        .loadValue(grossTarget),
        .expired(grossExpired)
    );

    // events that set a radio sub-source this cycle
    always_comb begin
        srcSet = SRC_RST;
        srcSet[SRC_FINE] = fineExpired;
        srcSet[SRC_GROSS] = grossExpired;
        srcSet[SRC_TICK] = st_r.baseTick && !radioSleeping;
        srcSet[SRC_SLEEP_END] = st_r.sleepPrev && !radioSleeping;
        srcSet[SRC_FAULT] = radioFault;
        srcSet[SRC_RX] = radioRxDone;
        srcSet[SRC_EVENT] = radioEventEnd;
        srcSet[SRC_LINK_CRYPT] = linkAesDone || linkCcmDone;
        srcSet[SRC_SW] = software_request_event;
    end

    // next-state logic for ticks, sticky sources and lines
    always_comb begin
        st_nxt = st_r;
        // base reference keeps running in sleep so timers stay aligned
        st_nxt.baseTick = 1'b0;
        if (st_r.baseCnt == BASE_CNT_W'(BASE_TICK_LEN - 1)) begin
            st_nxt.baseCnt = '0;
            st_nxt.baseTick = 1'b1;
        end else begin
            st_nxt.baseCnt = BASE_CNT_W'(st_r.baseCnt + 1'b1);
        end
        if (st_r.baseTick) begin
            st_nxt.grossPre = 4'(st_r.grossPre + 4'h1);
        end
        st_nxt.sleepPrev = radioSleeping;
        // a set in the clearing cycle is kept
        st_nxt.pend = (st_r.pend & ~radioSrcClear) | srcSet;
        st_nxt.lines = LINE_RST;
        st_nxt.lines[LINE_WAKEUP] = radioSleepWakeupReq;
        st_nxt.lines[LINE_RADIO] = |st_nxt.pend;
        st_nxt.lines[LINE_RSVD_A] = 1'b0;
        st_nxt.lines[LINE_RSVD_B] = 1'b0;
        st_nxt.lines[LINE_RFCAL] = rfCalIrq;
        st_nxt.lines[LINE_ARBITER] = arbiterIrq;
        st_nxt.lines[LINE_CRYPTO] = aesHashIrq || eccIrq;
        // presented line tracks the registered lines, one cycle later
        st_nxt.presValid = |st_r.lines;
        st_nxt.presLine = silm_lowest(st_r.lines);
    end

    // state register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '{baseCnt: '0, baseTick: 1'b0, grossPre: 4'h0,
                      sleepPrev: 1'b0, pend: SRC_RST, lines: LINE_RST,
                      presValid: 1'b0, presLine: PRES_LINE_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign irqLine = st_r.lines;
    assign radioSrcPending = st_r.pend;
    assign firstLineValid = st_r.presValid;
    assign firstLine = st_r.presLine;

endmodule // silm_line_map

/* silm_line_map_sva.sv */
// port assertions for the interrupt line mapper
// assumes bind onto silm_line_map, one clock domain
module silm_line_map_sva
    import silm_pkg::*;
#(
    parameter int unsigned BASE_TICK_LEN = 20 // cycles per tick
) (
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic radioSleepWakeupReq, // wake request
    input wire logic radioFault, // fault pulse
    input wire logic radioRxDone, // rx pulse
    input wire logic software_request_event, // sw pulse
    input wire logic [SRC_COUNT-1:0] radioSrcClear, // clears
    input wire logic rfCalIrq, // rf calibration
    input wire logic arbiterIrq, // arbiter
    input wire logic aesHashIrq, // aes or hash
    input wire logic eccIrq, // curve engine
    input wire logic [LINE_COUNT-1:0] irqLine, // lines out
    input wire logic [SRC_COUNT-1:0] radioSrcPending, // held sources
    input wire logic firstLineValid // any line
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // level lines lag their inputs by one edge; skip edge after reset
    AST_WAKE: assert property (!$past(sys_rst) |->
        irqLine[0] == $past(radioSleepWakeupReq)) else $error("wake line");
    AST_RFCAL: assert property (!$past(sys_rst) |->
        irqLine[4] == $past(rfCalIrq)) else $error("rfcal line");
    AST_CRYPTO: assert property (!$past(sys_rst) |->
        irqLine[6] == $past(aesHashIrq | eccIrq)) else $error("crypto line");
    AST_ARB_RSVD: assert property (!$past(sys_rst) |->
        irqLine[5] == $past(arbiterIrq) && irqLine[3:2] == 2'b00)
        else $error("arbiter or reserved line");
    AST_RX: assert property (radioRxDone |=>
        radioSrcPending[SRC_RX]) else $error("rx source");
    AST_SW: assert property (software_request_event |=>
        radioSrcPending[SRC_SW]) else $error("sw source");
    AST_FAULT_HOLD: assert property (radioFault ||
        radioSrcPending[SRC_FAULT] && !radioSrcClear[SRC_FAULT] |=>
        radioSrcPending[SRC_FAULT]) else $error("fault source");
    AST_RADIO_OR: assert property (
        irqLine[1] == |radioSrcPending) else $error("radio line");
    AST_FIRST: assert property (!$past(sys_rst) |->
        firstLineValid == $past(|irqLine)) else $error("first valid");
endmodule // silm_line_map_sva

bind silm_line_map silm_line_map_sva #(.BASE_TICK_LEN(BASE_TICK_LEN)) u_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .radioSleepWakeupReq(radioSleepWakeupReq), .radioFault(radioFault),
    .radioRxDone(radioRxDone),
    .software_request_event(software_request_event),
    .radioSrcClear(radioSrcClear), .rfCalIrq(rfCalIrq),
    .arbiterIrq(arbiterIrq), .aesHashIrq(aesHashIrq), .eccIrq(eccIrq),
    .irqLine(irqLine), .radioSrcPending(radioSrcPending),
    .firstLineValid(firstLineValid));

/* silm_cpu_model.sv */
// model of the processor's interrupt inputs
// assumes active-high level lines on sys_clk
module silm_cpu_model
    import silm_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [LINE_COUNT-1:0] irqLine, // lines in
    input wire logic [LINE_COUNT-1:0] ack, // handler entry
    output logic [LINE_COUNT-1:0] pend_r // latched requests
);
    // latch until acked, so a short level is never lost
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_r <= LINE_RST;
        end else begin
            pend_r <= (pend_r & ~ack) | irqLine;
        end
    end
endmodule // silm_cpu_model

/* silm_line_map_tb.sv */
// self-checking bench for the interrupt line mapper
// assumes the package, checker and processor model compile first
module silm_line_map_tb import silm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 20;
    logic sys_clk = 1'b0, sys_rst = 1'b1, wake = 0, sleeping = 1;
    logic fLoad = 0, gLoad = 0, fValid;
    logic [TIMER_W-1:0] fTgt = '0, gTgt = '0;
    logic [5:0] pulses = '0; // sw,ccm,aes,event,rx,fault
    logic [3:0] lvl = '0; // ecc,aeshash,arbiter,rfcal
    logic [SRC_COUNT-1:0] clr = '0, srcPend;
    logic [LINE_COUNT-1:0] irqLine, ack = '0, pend_r;
    logic [2:0] fLine;
    int err_count = 0, samples_checked = 0;
    // free-running clock
    always #5 sys_clk = ~sys_clk;
    silm_line_map #(.BASE_TICK_LEN(TICK)) DUT (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .radioSleepWakeupReq(wake),
        .radioSleeping(sleeping), .fineLoad(fLoad), .fineTarget(fTgt),
        .grossLoad(gLoad), .grossTarget(gTgt), .radioFault(pulses[0]),
        .radioRxDone(pulses[1]), .radioEventEnd(pulses[2]),
        .linkAesDone(pulses[3]), .linkCcmDone(pulses[4]),
        .software_request_event(pulses[5]), .radioSrcClear(clr),
        .rfCalIrq(lvl[0]), .arbiterIrq(lvl[1]), .aesHashIrq(lvl[2]),
        .eccIrq(lvl[3]), .irqLine(irqLine), .radioSrcPending(srcPend),
        .firstLineValid(fValid), .firstLine(fLine));
    silm_cpu_model u_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .irqLine(irqLine), .ack(ack), .pend_r(pend_r));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wt(input int b, input int lim, output int n);
        n = 0;
        while (srcPend[b] !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
    endtask
    // each level source alone, then three at once for the hint
    task automatic t_levels();
        logic [6:0] map [5] = '{7'h01, 7'h10, 7'h20, 7'h40, 7'h40};
        logic [2:0] num [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h6};
        for (int i = 0; i < 5; i++) begin
            {lvl, wake} = 5'h01 << i;
            cyc(1);
            chk(16'(irqLine), 16'(map[i]));
            cyc(1);
            chk(16'({fValid, fLine}), 16'({1'b1, num[i]}));
        end
        {lvl, wake} = 5'h1C;
        cyc(2);
        chk(16'(fLine), 16'h0005);
        chk(16'(pend_r), 16'h0071);
        {lvl, wake} = '0;
        ack = '1;
        cyc(2);
        ack = '0;
    endtask
    // radio pulses stay held until cleared; asleep so no tick source
    task automatic t_pulses();
        int bitOf [6] = '{4, 5, 6, 7, 7, 8};
        for (int i = 0; i < 6; i++) begin
            pulses = 6'h01 << i;
            cyc(1);
            pulses = '0;
            chk(16'(srcPend), 16'h0001 << bitOf[i]);
            cyc(3);
            chk(16'(irqLine[1]), 16'h0001);
            clr = '1;
            cyc(1);
            clr = '0;
            chk(16'(srcPend), 16'h0000);
        end
    endtask
    // tick refused in sleep; leaving sleep and ticks set sources
    task automatic t_tick();
        int n;
        cyc(3 * TICK);
        chk(16'(srcPend), 16'h0000);
        sleeping = 0;
        cyc(2);
        chk(16'(srcPend[SRC_SLEEP_END]), 16'h0001);
        wt(SRC_TICK, 2 * TICK, n);
        chk(16'(n <= TICK), 16'h0001);
        sleeping = 1;
        clr = '1;
        cyc(1);
        clr = '0;
    endtask
    // expiry time bracketed by whole base ticks of unknown phase
    task automatic t_timers();
        int n;
        {fTgt, gTgt} = {16'h0003, 16'h0002};
        {fLoad, gLoad} = 2'b11;
        cyc(1);
        {fLoad, gLoad} = 2'b00;
        wt(SRC_FINE, 5 * TICK, n);
        chk(16'(n > 2 * TICK - 3 && n <= 3 * TICK + 3), 16'h0001);
        wt(SRC_GROSS, 40 * TICK, n);
        chk(16'(n > 13 * TICK && n <= 29 * TICK + 3), 16'h0001);
    endtask
    task automatic give_verdict();
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(3);
        sys_rst = 0;
        t_levels();
        t_pulses();
        t_tick();
        t_timers();
        give_verdict();
    end
    // watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #40000;
        err_count++;
        give_verdict();
    end
endmodule // silm_line_map_tb
